// [shared/ptet_defines.svh]
// Register offsets, field positions and reset values of the trigger block
`ifndef PTET_DEFINES_SVH
`define PTET_DEFINES_SVH
// Byte addresses of the register words
`define PTET_OFF_IDX   16'h0500
`define PTET_OFF_TSC   16'h052c
`define PTET_OFF_NS    16'h0530
`define PTET_OFF_SEC   16'h0534
`define PTET_OFF_CTL   16'h0538
`define PTET_OFF_STS   16'h0540
`define PTET_OFF_MSK   16'h0544
// Unit index register fields
`define PTET_F_TIDX    1:0
`define PTET_B_SIDX    8
`define PTET_IDX_MASK  32'h0000_0103
// Timestamp control and status fields
`define PTET_B_TSCLR   0
`define PTET_B_TSEN    1
`define PTET_B_TRCLR   2
`define PTET_B_TREN    3
`define PTET_B_TRACT   4
// Trigger control fields
`define PTET_B_CHAIN   31
`define PTET_B_TAIL    30
`define PTET_F_SEL     27:26
`define PTET_B_NOW     25
`define PTET_B_NTFY    24
`define PTET_B_EDGE    23
`define PTET_F_PAT     22:20
`define PTET_CTL_MASK  32'hcff0_0000
// Reset values and widths
`define PTET_RST32     32'h0000_0000
`define PTET_NS_W      30
`define PTET_WAVE_RST  1'h1
// Output pattern codes
`define PTET_PAT_NEDGE 3'h0
`define PTET_PAT_PEDGE 3'h1
`define PTET_PAT_SER   3'h6
`define PTET_PAT_RSV   3'h7
// Bus responses
`define PTET_OKAY      2'h0
`define PTET_SLVERR    2'h2
`endif

// [shared/ptet_pkg.sv]
// Types shared by the trigger block modules
package ptet_pkg;
   // Trigger unit sequencer states
   typedef enum logic [1:0] {
      st_idle,
      st_wait,
      st_launch,
      st_run
   } ptet_state_t;
endpackage : ptet_pkg

// [shared/ptet_unit_if.sv]
// Signals between the register block and one trigger unit core
`timescale 1ns/100ps
`default_nettype none
interface ptet_unit_if;
   logic [31:0] tgt_sec;
   logic [29:0] tgt_ns;
   logic [2:0]  pattern;
   logic        now_en;
   logic        edge_neg;
   logic        arm;
   logic        chain_arm;
   logic        clear;
   logic        waiting;
   logic        active;
   logic        done_p;
   logic        fault_p;
   logic        wave;
   modport ctl  (output tgt_sec, tgt_ns, pattern, now_en, edge_neg, arm, chain_arm,
                 clear, input waiting, active, done_p, fault_p, wave);
   modport core (input tgt_sec, tgt_ns, pattern, now_en, edge_neg, arm, chain_arm,
                 clear, output waiting, active, done_p, fault_p, wave);
endinterface : ptet_unit_if
`default_nettype wire

// [hw/ptet_unit_core.sv]
// One trigger unit: time compare, launch and waveform sequencer
`timescale 1ns/100ps
`default_nettype none
`include "ptet_defines.svh"
module ptet_unit_core
   import ptet_pkg::*;
#(
   parameter logic [15:0] PULSE_CYC  = 16'h0004,
   parameter logic [15:0] PERIOD_CYC = 16'h0008,
   parameter logic [15:0] BIT_CYC    = 16'h0004,
   parameter logic [15:0] CYCLE_CNT  = 16'h0000,
   parameter logic [15:0] PATTERN    = 16'ha5f0
)(
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // System time
   input  wire logic [31:0] sys_sec,
   input  wire logic [29:0] sys_ns,
   // Register side
   ptet_unit_if.core        u
);
   ptet_state_t st_q;
   logic [15:0] ph_q, n_q;
   logic        wave_q, done_q, fault_q;

   // Seconds first, then nanoseconds
   wire        reached = {sys_sec, sys_ns} >= {u.tgt_sec, u.tgt_ns};
   wire        late    = {sys_sec, sys_ns} >  {u.tgt_sec, u.tgt_ns};
   wire        start   = u.arm || u.chain_arm;
   // Chained restarts tolerate a past target; only a software arm faults
   wire        refuse  = late && !u.now_en && !u.chain_arm;
   wire        one     = u.pattern[2:1] == 2'h1;
   wire        ser     = u.pattern == `PTET_PAT_SER;
   // One-shot pulse needs a closing step after its active cycles
   wire [15:0] len     = ser ? BIT_CYC : (one ? 16'(PULSE_CYC + 16'h0001) : PERIOD_CYC);
   wire [15:0] limit   = one ? 16'h0001 : CYCLE_CNT;
   wire        last    = ph_q == 16'(len - 16'h0001);
   wire        fin     = last && (limit != 16'h0000) && (16'(n_q + 16'h0001) == limit);
   wire        lvl     = ser ? PATTERN[4'hf - n_q[3:0]]
                             : ((ph_q < PULSE_CYC) ? u.pattern[0] : !u.pattern[0]);
   wire        edge_p  = u.pattern[2:1] == 2'h0;

   // Sequencer: idle, wait for time, optional one-cycle launch step, run waveform
   always_ff @(posedge aclk) begin
      done_q  <= 1'b0;
      fault_q <= 1'b0;
      if (!aresetn || u.clear) begin
         st_q   <= st_idle;
         wave_q <= `PTET_WAVE_RST;
         ph_q   <= 16'h0000;
         n_q    <= 16'h0000;
      end else begin
         case (st_q)
            st_idle: if (start) begin
               if (refuse) fault_q <= 1'b1;
               else begin
                  st_q   <= st_wait;
                  // Reserved code keeps the pin where it is
                  if (u.pattern != `PTET_PAT_RSV) wave_q <= !u.pattern[0];
               end
            end
            st_wait: if (reached) begin
               st_q <= u.edge_neg ? st_launch : st_run;
               ph_q <= 16'h0000;
               n_q  <= 16'h0000;
            end
            st_launch: st_q <= st_run;
            st_run: begin
               if (u.pattern == `PTET_PAT_RSV) begin
                  fault_q <= 1'b1;
                  st_q    <= st_idle;
               end else if (edge_p) begin
                  wave_q <= u.pattern[0];
                  done_q <= 1'b1;
                  st_q   <= st_idle;
               end else if (fin) begin
                  wave_q <= ser ? lvl : !u.pattern[0];
                  done_q <= 1'b1;
                  st_q   <= st_idle;
               end else begin
                  wave_q <= lvl;
                  ph_q   <= last ? 16'h0000 : 16'(ph_q + 16'h0001);
                  n_q    <= last ? 16'(n_q + 16'h0001) : n_q;
               end
            end
            default: st_q <= st_idle;
         endcase
      end
   end

   // Enable reads back as armed and clears once launched
   assign u.waiting = (st_q == st_wait) || (st_q == st_launch);
   assign u.active  = st_q != st_idle;
   assign u.done_p  = done_q;
   assign u.fault_p = fault_q;
   assign u.wave    = wave_q;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_fire;
      // Falling launch keeps the enable one cycle longer
      st_q == st_wait && reached && !u.clear |=> st_q != st_wait ##1 !u.waiting;
   endproperty
   a_fire: assert property (p_fire) else $error("unit missed its target time");
   property p_hold;
      st_q == st_wait && !reached && !u.clear |=> st_q == st_wait;
   endproperty
   a_hold: assert property (p_hold) else $error("unit fired before target");
   property p_late;
      st_q == st_idle && u.arm && !u.chain_arm && late && !u.now_en && !u.clear
      |=> u.fault_p && st_q == st_idle;
   endproperty
   a_late: assert property (p_late) else $error("late target not refused");
   property p_now;
      st_q == st_idle && u.arm && late && u.now_en && !u.clear
      |=> st_q == st_wait ##1 st_q != st_wait;
   endproperty
   a_now: assert property (p_now) else $error("trigger now did not fire");
   property p_edge;
      st_q == st_wait && reached && u.edge_neg && !u.clear
      |=> st_q == st_launch ##1 st_q == st_run;
   endproperty
   a_edge: assert property (p_edge) else $error("falling launch step skipped");
   property p_rsv;
      st_q == st_run && u.pattern == `PTET_PAT_RSV && !u.clear
      |=> u.fault_p && $stable(wave_q);
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved pattern drove output");
endmodule : ptet_unit_core
`default_nettype wire

// [hw/ptet_trigger_top.sv]
// Event trigger output block: AXI4-Lite registers, chaining and interrupt
`timescale 1ns/100ps
`default_nettype none
`include "ptet_defines.svh"
// Operation
// - Capture soft clear bit 0 returns the capture unit to inactive defaults
// - Capture soft clear acts only on the unit chosen by index bit 8
// - Nanosecond register accesses reach the unit chosen by index bits 1:0
// - Nanosecond target register, bits 31:30 read zero, resets to zero
// - Seconds target register, full 32 bits read/write, resets to zero
// - Control bit 31 puts the unit into chained mode
// - Control bit 30 marks the unit as the chain tail
// - Chain without a tail repeats endlessly until the unit soft clear
// - Field 27:26 picks the upstream unit whose done starts this unit
// - Bit 25 fires a late target at once, else refuses it with a fault; a chained start with a late target is never refused
// - Bit 24 gates done and fault flags and their interrupt
// - Bit 23 selects falling rather than rising launch edge
// - Trigger enable clears itself once output is launched
// - Unit soft clear returns unit to inactive state and defaults
// - Field 22:20 selects output waveform; code 111 is reserved
module ptet_trigger_top
   import ptet_pkg::*;
#(
   parameter int          NU         = 4,
   parameter int          AW         = 16,
   parameter logic [15:0] PULSE_CYC  = 16'h0004,
   parameter logic [15:0] PERIOD_CYC = 16'h0008,
   parameter logic [15:0] BIT_CYC    = 16'h0004,
   parameter logic [15:0] CYCLE_CNT  = 16'h0000,
   parameter logic [15:0] PATTERN    = 16'ha5f0
)(
   // Clock and reset
   input  wire logic          aclk,
   input  wire logic          aresetn,
   // Write address channel
   input  wire logic [AW-1:0] awaddr,
   input  wire logic          awvalid,
   output var  logic          awready,
   // Write data channel
   input  wire logic [31:0]   wdata,
   input  wire logic [3:0]    wstrb,
   input  wire logic          wvalid,
   output var  logic          wready,
   // Write response channel
   output var  logic [1:0]    bresp,
   output var  logic          bvalid,
   input  wire logic          bready,
   // Read address channel
   input  wire logic [AW-1:0] araddr,
   input  wire logic          arvalid,
   output var  logic          arready,
   // Read data channel
   output var  logic [31:0]   rdata,
   output var  logic [1:0]    rresp,
   output var  logic          rvalid,
   input  wire logic          rready,
   // System time, same clock
   input  wire logic [31:0]   sys_sec,
   input  wire logic [29:0]   sys_ns,
   // Trigger outputs and interrupt
   output var  logic [NU-1:0] trig_out,
   output var  logic          irq
);
   // Bus side registers
   logic          awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic [1:0]    bresp_q, rresp_q;
   logic [31:0]   rdata_q;
   logic          awh_q, wh_q;
   logic [AW-1:0] awa_q;
   logic [31:0]   wd_q;
   logic [3:0]    ws_q;
   // Block registers
   logic [31:0]   idx_q;
   logic [1:0]    ts_en_q;
   logic [2*NU-1:0] sts_q, msk_q;
   logic [NU-1:0] trig_q;
   logic          irq_q;

   // Per-unit views gathered for chaining and readback
   logic [NU-1:0] done_v, flt_v, tail_v, wait_v, act_v, wave_v, ntfy_v;
   logic [29:0]   ns_v  [NU];
   logic [31:0]   sec_v [NU];
   logic [31:0]   ctl_v [NU];

   // Handshakes of the three request channels
   wire aw_ok = awvalid && awready_q;
   wire w_ok  = wvalid && wready_q;
   wire ar_ok = arvalid && arready_q;
   // Write runs once address and data are both held and response is free
   wire wr_go = awh_q && wh_q && !bvalid_q;

   // Byte lane mask of the held write
   wire [31:0] wm  = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
   wire [31:0] wdm = wd_q & wm;

   // Write address decode
   wire w_idx = awa_q == `PTET_OFF_IDX;
   wire w_tsc = awa_q == `PTET_OFF_TSC;
   wire w_ns  = awa_q == `PTET_OFF_NS;
   wire w_sec = awa_q == `PTET_OFF_SEC;
   wire w_ctl = awa_q == `PTET_OFF_CTL;
   wire w_sts = awa_q == `PTET_OFF_STS;
   wire w_msk = awa_q == `PTET_OFF_MSK;
   wire w_hit = w_idx || w_tsc || w_ns || w_sec || w_ctl || w_sts || w_msk;

   // Index pointers
   wire [1:0] tidx = idx_q[`PTET_F_TIDX];
   wire       sidx = idx_q[`PTET_B_SIDX];

   // Read decode and data selection
   wire r_idx = araddr == `PTET_OFF_IDX;
   wire r_tsc = araddr == `PTET_OFF_TSC;
   wire r_ns  = araddr == `PTET_OFF_NS;
   wire r_sec = araddr == `PTET_OFF_SEC;
   wire r_ctl = araddr == `PTET_OFF_CTL;
   wire r_sts = araddr == `PTET_OFF_STS;
   wire r_msk = araddr == `PTET_OFF_MSK;
   wire r_hit = r_idx || r_tsc || r_ns || r_sec || r_ctl || r_sts || r_msk;
   wire [31:0] tsc_rd = {27'h0000000, act_v[tidx], wait_v[tidx], 1'b0,
                         ts_en_q[sidx], 1'b0};
   wire [31:0] rd_val =
      r_idx ? idx_q :
      r_tsc ? tsc_rd :
      r_ns  ? {2'h0, ns_v[tidx]} :
      r_sec ? sec_v[tidx] :
      r_ctl ? ctl_v[tidx] :
      r_sts ? 32'(sts_q) :
      r_msk ? 32'(msk_q) : `PTET_RST32;

   // Status set and clear terms; notify gates both flags
   wire [2*NU-1:0] sts_set = {flt_v & ntfy_v, done_v & ntfy_v};
   wire [2*NU-1:0] sts_clr = (wr_go && w_sts) ? wdm[2*NU-1:0] : '0;
   wire [2*NU-1:0] sts_d   = (sts_q & ~sts_clr) | sts_set;

   // Write address and data holding
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awh_q <= 1'b0;
         wh_q  <= 1'b0;
      end else begin
         awh_q <= aw_ok || (awh_q && !wr_go);
         wh_q  <= w_ok || (wh_q && !wr_go);
      end
   end

   // Payload capture needs no reset
   always_ff @(posedge aclk) begin
      if (aw_ok) awa_q <= awaddr;
      if (w_ok) begin
         wd_q <= wdata;
         ws_q <= wstrb;
      end
   end

   // Ready goes low while a beat is held, returns after the write runs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
      end else begin
         awready_q <= !(aw_ok || (awh_q && !wr_go));
         wready_q  <= !(w_ok || (wh_q && !wr_go));
      end
   end

   // Write response; unmapped addresses answer SLVERR
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= `PTET_OKAY;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         bresp_q  <= w_hit ? `PTET_OKAY : `PTET_SLVERR;
      end else if (bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // Read channel: one read in flight, data from a register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= `PTET_RST32;
         rresp_q   <= `PTET_OKAY;
      end else if (ar_ok) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rdata_q   <= rd_val;
         rresp_q   <= r_hit ? `PTET_OKAY : `PTET_SLVERR;
      end else if (rvalid_q && rready) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
      end
   end

   // Unit index pointers
   always_ff @(posedge aclk) begin
      if (!aresetn) idx_q <= `PTET_RST32;
      else if (wr_go && w_idx) idx_q <= ((idx_q & ~wm) | wdm) & `PTET_IDX_MASK;
   end

   // Capture unit enables; soft clear acts on the indexed unit only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ts_en_q <= 2'h0;
      end else if (wr_go && w_tsc && ws_q[0]) begin
         if (wdm[`PTET_B_TSCLR]) ts_en_q[sidx] <= 1'b0;
         else ts_en_q[sidx] <= wdm[`PTET_B_TSEN];
      end
   end

   // Sticky status, write one to clear; set wins over clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sts_q <= '0;
         msk_q <= '0;
      end else begin
         sts_q <= sts_d;
         if (wr_go && w_msk) msk_q <= ((msk_q & ~wm[2*NU-1:0]) | wdm[2*NU-1:0]);
      end
   end

   // Interrupt level and trigger pins straight from flops
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_q  <= 1'b0;
         trig_q <= {NU{`PTET_WAVE_RST}};
      end else begin
         irq_q  <= |(sts_d & msk_q);
         trig_q <= wave_v;
      end
   end

   assign awready  = awready_q;
   assign wready   = wready_q;
   assign bvalid   = bvalid_q;
   assign bresp    = bresp_q;
   assign arready  = arready_q;
   assign rvalid   = rvalid_q;
   assign rdata    = rdata_q;
   assign rresp    = rresp_q;
   assign irq      = irq_q;
   assign trig_out = trig_q;

   // One register set and sequencer per trigger unit
   for (genvar i = 0; i < NU; i++) begin : g_unit
      ptet_unit_if u ();
      logic [29:0] ns_q;
      logic [31:0] sec_q, ctl_q;
      logic        arm_q, clr_q;
      wire         me  = wr_go && (tidx == 2'(i));
      wire  [1:0]  up  = ctl_q[`PTET_F_SEL];

      // Enable and soft clear bits act as one-cycle strobes
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            arm_q <= 1'b0;
            clr_q <= 1'b0;
         end else begin
            arm_q <= me && w_tsc && wdm[`PTET_B_TREN];
            clr_q <= me && w_tsc && wdm[`PTET_B_TRCLR];
         end
      end

      // Target time and control; soft clear restores defaults
      always_ff @(posedge aclk) begin
         if (!aresetn || clr_q) begin
            ns_q  <= 30'(`PTET_RST32);
            sec_q <= `PTET_RST32;
            ctl_q <= `PTET_RST32;
         end else begin
            if (me && w_ns)  ns_q  <= ((ns_q & ~wm[29:0]) | wdm[29:0]);
            if (me && w_sec) sec_q <= (sec_q & ~wm) | wdm;
            if (me && w_ctl) ctl_q <= ((ctl_q & ~wm) | wdm) & `PTET_CTL_MASK;
         end
      end

      // Chained start from the selected upstream done; a tail ends the loop
      assign u.chain_arm = ctl_q[`PTET_B_CHAIN] && done_v[up]
                           && !tail_v[up];
      assign u.arm       = arm_q;
      assign u.clear     = clr_q;
      assign u.tgt_sec   = sec_q;
      assign u.tgt_ns    = ns_q;
      assign u.pattern   = ctl_q[`PTET_F_PAT];
      assign u.now_en    = ctl_q[`PTET_B_NOW];
      assign u.edge_neg  = ctl_q[`PTET_B_EDGE];

      assign done_v[i] = u.done_p;
      assign flt_v[i]  = u.fault_p;
      assign wait_v[i] = u.waiting;
      assign act_v[i]  = u.active;
      assign wave_v[i] = u.wave;
      assign tail_v[i] = ctl_q[`PTET_B_CHAIN] && ctl_q[`PTET_B_TAIL];
      assign ntfy_v[i] = ctl_q[`PTET_B_NTFY];
      assign ns_v[i]   = ns_q;
      assign sec_v[i]  = sec_q;
      assign ctl_v[i]  = ctl_q;

      ptet_unit_core #(
         .PULSE_CYC  (PULSE_CYC),
         .PERIOD_CYC (PERIOD_CYC),
         .BIT_CYC    (BIT_CYC),
         .CYCLE_CNT  (CYCLE_CNT),
         .PATTERN    (PATTERN)
      ) u_core (
         .aclk    (aclk),
         .aresetn (aresetn),
         .sys_sec (sys_sec),
         .sys_ns  (sys_ns),
         .u       (u.core)
      );
   end

   // Checks on the register side
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_ns_rsv;
      ar_ok && r_ns |=> rvalid_q && rdata_q[31:30] == 2'h0;
   endproperty
   a_ns_rsv: assert property (p_ns_rsv) else $error("ns reserved bits nonzero");
   property p_idx;
      wr_go && w_ns && tidx == 2'h2 && ws_q == 4'hf
      |=> ns_v[2] == $past(wd_q[29:0]);
   endproperty
   a_idx: assert property (p_idx) else $error("ns write missed indexed unit");
   property p_ts;
      wr_go && w_tsc && ws_q[0] && wdm[`PTET_B_TSCLR] && sidx
      |=> ts_en_q[1] == 1'b0 && ts_en_q[0] == $past(ts_en_q[0]);
   endproperty
   a_ts: assert property (p_ts) else $error("capture clear hit wrong unit");
   property p_soft;
      g_unit[1].clr_q |=> g_unit[1].ctl_q == `PTET_RST32 && !act_v[1];
   endproperty
   a_soft: assert property (p_soft) else $error("unit soft clear incomplete");
   property p_ntfy;
      done_v[0] && !ntfy_v[0] && !sts_q[0] |=> !sts_q[0];
   endproperty
   a_ntfy: assert property (p_ntfy) else $error("done flag set without notify");

   c_write: cover property (wr_go && w_ctl);
   c_fire:  cover property (done_v[0] && ntfy_v[0] ##1 irq_q);
   c_chain: cover property (g_unit[1].u.chain_arm ##[1:40] done_v[1]);
endmodule : ptet_trigger_top
`default_nettype wire

// [tb/ptet_pin_monitor.sv]
// Model of the equipment on the trigger pins: counts falling edges
`timescale 1ns/100ps
`default_nettype none
module ptet_pin_monitor (
   // Clock
   input  wire logic            aclk,
   // Trigger pins from the block
   input  wire logic [3:0]      pins,
   // Falling edges seen per pin
   output var  logic [3:0][7:0] n_fall
);
   logic [3:0] pins_q;
   // Sampled at the clock, like a synchronous input stage would
   initial n_fall = '0;
   always @(posedge aclk) begin
      pins_q <= pins;
      for (int i = 0; i < 4; i++) begin
         if (pins_q[i] === 1'b1 && pins[i] === 1'b0) n_fall[i] <= n_fall[i] + 8'h01;
      end
   end
endmodule : ptet_pin_monitor
`default_nettype wire

// [tb/ptet_trigger_output_unit_tb_top.sv]
// Register and trigger tests of the event trigger output block
`timescale 1ns/100ps
`default_nettype none
`include "ptet_defines.svh"
module ptet_trigger_output_unit_tb_top;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic [15:0] awaddr, araddr;
   logic [31:0] wdata, rd, sys_sec;
   logic [29:0] sys_ns;
   logic [1:0]  rs;
   int          n_errors, samples_checked, lat0, lat1;
   logic [7:0]  f0;
   wire logic   awready, wready, bvalid, arready, rvalid, irq;
   wire logic [1:0]      bresp, rresp;
   wire logic [31:0]     rdata;
   wire logic [3:0]      trig_out;
   wire logic [3:0][7:0] n_fall;
   // Block under test, all byte lanes enabled
   ptet_trigger_top dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
      .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .sys_sec, .sys_ns, .trig_out, .irq);
   ptet_pin_monitor eqp (.aclk, .pins(trig_out), .n_fall);
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   task automatic finish_test;
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : finish_test
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Write and hold each channel until it is taken
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      rs = bresp;
      bready <= 1'b0;
   endtask : wr
   task automatic rc(input logic [15:0] a, input string nm, input logic [31:0] e);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
      chk(nm, e, rd);
   endtask : rc
   // Arm unit 0, then move time onto the target and count cycles to the pin change
   task automatic fire(input logic [31:0] ctl, output int n);
      sys_ns <= 30'h0;
      wr(`PTET_OFF_CTL, ctl);
      wr(`PTET_OFF_TSC, 32'h0000_0008);
      repeat (8) @(posedge aclk);
      chk("pin before target", 32'h1, trig_out[0]);
      sys_ns <= 30'h64;
      n = 0;
      do begin
         @(posedge aclk);
         #1;
         n++;
      end while (trig_out[0] !== 1'b0 && n < 40);
      repeat (10) @(posedge aclk);
   endtask : fire
   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata} = '0;
      sys_sec = 32'h5;
      sys_ns  = 30'h0;
      aresetn = 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rc(`PTET_OFF_NS, "ns reset", 32'h0);
      rc(`PTET_OFF_SEC, "sec reset", 32'h0);
      wr(`PTET_OFF_NS, 32'h64);
      wr(`PTET_OFF_SEC, 32'h5);
      wr(`PTET_OFF_IDX, 32'h2);
      wr(`PTET_OFF_NS, 32'hffff_ffff);
      rc(`PTET_OFF_NS, "ns top bits", 32'h3fff_ffff);
      wr(`PTET_OFF_SEC, 32'ha5a5_0f0f);
      rc(`PTET_OFF_SEC, "sec value", 32'ha5a5_0f0f);
      wr(`PTET_OFF_CTL, 32'hffff_ffff);
      rc(`PTET_OFF_CTL, "ctl fields", 32'hcff0_0000);
      wr(`PTET_OFF_TSC, 32'h0000_0004);
      rc(`PTET_OFF_NS, "ns soft clear", 32'h0);
      rc(`PTET_OFF_CTL, "ctl soft clear", 32'h0);
      wr(`PTET_OFF_IDX, 32'h0);
      rc(`PTET_OFF_NS, "ns unit 0", 32'h64);
      // Capture unit 1 enabled, then cleared via the other index first
      wr(`PTET_OFF_IDX, 32'h100);
      wr(`PTET_OFF_TSC, 32'h2);
      wr(`PTET_OFF_IDX, 32'h0);
      wr(`PTET_OFF_TSC, 32'h1);
      wr(`PTET_OFF_IDX, 32'h100);
      rc(`PTET_OFF_TSC, "capture other", 32'h2);
      wr(`PTET_OFF_TSC, 32'h1);
      rc(`PTET_OFF_TSC, "capture clear", 32'h0);
      wr(`PTET_OFF_IDX, 32'h0);
      rc(16'h0600, "unmapped data", 32'h0);
      chk("unmapped resp", `PTET_SLVERR, rs);
      wr(`PTET_OFF_MSK, 32'h1);
      fire(32'h0100_0000, lat0);
      chk("fire latency", 32'h3, lat0);
      rc(`PTET_OFF_STS, "done status", 32'h1);
      chk("irq set", 32'h1, irq);
      wr(`PTET_OFF_STS, 32'h1);
      chk("irq clear", 32'h0, irq);
      rc(`PTET_OFF_TSC, "enable self clear", 32'h0);
      fire(32'h0180_0000, lat1);
      chk("falling launch", lat0 + 1, lat1);
      wr(`PTET_OFF_STS, 32'hff);
      // Late target: refused without now, launched with now
      sys_ns <= 30'hc8;
      wr(`PTET_OFF_CTL, 32'h0100_0000);
      wr(`PTET_OFF_TSC, 32'h8);
      repeat (10) @(posedge aclk);
      rc(`PTET_OFF_STS, "late fault", 32'h10);
      wr(`PTET_OFF_STS, 32'hff);
      f0 = n_fall[0];
      wr(`PTET_OFF_CTL, 32'h0320_0000);
      wr(`PTET_OFF_TSC, 32'h8);
      repeat (20) @(posedge aclk);
      rc(`PTET_OFF_STS, "now done", 32'h1);
      chk("pulse falls", f0 + 8'h01, n_fall[0]);
      chk("pulse end", 32'h1, trig_out[0]);
      wr(`PTET_OFF_STS, 32'hff);
      wr(`PTET_OFF_CTL, 32'h0370_0000);
      wr(`PTET_OFF_TSC, 32'h8);
      repeat (20) @(posedge aclk);
      rc(`PTET_OFF_STS, "reserved pattern", 32'h10);
      chk("reserved pin", 32'h1, trig_out[0]);
      // Chain: unit 0 head, unit 1 tail started by the done of unit 0
      wr(`PTET_OFF_STS, 32'hff);
      sys_ns <= 30'h64;
      wr(`PTET_OFF_IDX, 32'h1);
      wr(`PTET_OFF_CTL, 32'hc100_0000);
      wr(`PTET_OFF_IDX, 32'h0);
      wr(`PTET_OFF_CTL, 32'h8500_0000);
      f0 = n_fall[1];
      wr(`PTET_OFF_TSC, 32'h8);
      repeat (20) @(posedge aclk);
      rc(`PTET_OFF_STS, "chain done", 32'h3);
      chk("tail stops", f0 + 8'h01, n_fall[1]);
      // No tail: loops until unit 1 soft clear; head has notify off
      wr(`PTET_OFF_STS, 32'hff);
      wr(`PTET_OFF_CTL, 32'h8400_0000);
      wr(`PTET_OFF_IDX, 32'h1);
      wr(`PTET_OFF_CTL, 32'h8100_0000);
      wr(`PTET_OFF_IDX, 32'h0);
      f0 = n_fall[1];
      wr(`PTET_OFF_TSC, 32'h8);
      repeat (30) @(posedge aclk);
      chk("chain loops", 32'h1, n_fall[1] > f0 + 8'h01);
      wr(`PTET_OFF_IDX, 32'h1);
      wr(`PTET_OFF_TSC, 32'h4);
      repeat (10) @(posedge aclk);
      f0 = n_fall[1];
      repeat (20) @(posedge aclk);
      chk("chain stopped", f0, n_fall[1]);
      rc(`PTET_OFF_STS, "notify off", 32'h2);
      finish_test();
   end
   // Hang guard, far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge aclk);
      n_errors++;
      finish_test();
   end
endmodule : ptet_trigger_output_unit_tb_top
`default_nettype wire
